// *** caq_sequencer.sv ***
// acquisition sequencer, output buffer, test modes and register file
`timescale 1ns/1ps
module caq_sequencer #(
    parameter int BUF_AW = caq_pkg::BUF_AW,
    parameter int MAX_EVT = caq_pkg::MAX_EVT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // register access
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    // front end
    input wire logic gate_in,
    input wire logic fast_clear_in,
    input wire logic [caq_pkg::NCH*13-1:0] chan_value_in,
    input wire logic [caq_pkg::NCH-1:0] chan_ovf_in,
    // status
    output logic busy_out,
    output logic data_ready_out,
    output logic buf_full_out,
    output logic [2:0] irq_level_out,
    output logic [7:0] irq_vector_out,
    output logic irq_enable_out
);
    localparam int NCH = caq_pkg::NCH;
    localparam logic [5:0] EVMAX = 6'(MAX_EVT);

    caq_fifo_if fif ();

    caq_test_fifo u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .f(fif.fifo)
    );

    // register group state
    logic [15:0] b2_q, b2_d, twh_q, twh_d;
    logic [7:0] mcst_q, mcst_d, ivec_q, ivec_d;
    logic [2:0] ilvl_q, ilvl_d;
    logic [BUF_AW-1:0] wta_q, wta_d, rta_q, rta_d, rptr_q, rptr_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic rd_eoe, ev_rst, tw_we, thr_we, thr_hit;
    logic [4:0] thr_idx;
    logic [8:0] thr_q [NCH];
    logic [31:0] rd_word;

    // sequencer group state
    caq_pkg::caq_state_type st_q, st_d;
    logic [15:0] tmr_q, tmr_d;
    logic [4:0] idx_q, idx_d;
    logic [5:0] cnt_q, cnt_d, evs_q, evs_d;
    logic [23:0] evc_q, evc_d;
    logic [BUF_AW-1:0] wptr_q, wptr_d, cnt_ext;
    logic [NCH*13-1:0] sv_q, sv_d;
    logic [NCH-1:0] so_q, so_d;
    logic gate_q, busy_q, busy_d, full_q, full_d, dr_q, dr_d;
    logic sq_we, acc, ovf;
    logic [BUF_AW-1:0] sq_wa;
    logic [31:0] sq_wd;
    logic [4:0] ch;
    logic [12:0] val;
    logic [8:0] thr;

    // buffer write port
    logic buf_we;
    logic [BUF_AW-1:0] buf_wa;
    logic [31:0] buf_wd;
    logic [31:0] buf_q [2**BUF_AW];

    assign thr_hit = (reg_addr_in >= caq_pkg::OFS_THR_LO) &&
        (reg_addr_in <= caq_pkg::OFS_THR_HI) && !reg_addr_in[0];
    assign thr_idx = reg_addr_in[5:1];
    assign rd_word = buf_q[rptr_q];

    // register decode: writes, reads and their side effects
    always_comb begin
        b2_d = b2_q;
        twh_d = twh_q;
        mcst_d = mcst_q;
        ivec_d = ivec_q;
        ilvl_d = ilvl_q;
        wta_d = wta_q;
        rta_d = rta_q;
        rptr_d = rptr_q;
        rdata_d = rdata_q;
        ack_d = reg_wr_in | reg_rd_in;
        rd_eoe = 1'b0;
        ev_rst = 1'b0;
        tw_we = 1'b0;
        thr_we = 1'b0;
        fif.push = 1'b0;
        fif.push_data = reg_wdata_in;
        fif.arm = 1'b0;
        fif.disarm = 1'b0;
        if (reg_wr_in) begin
            thr_we = thr_hit;
            case (reg_addr_in)
                caq_pkg::OFS_MCST: mcst_d = reg_wdata_in[7:0];
                caq_pkg::OFS_ILVL: ilvl_d = reg_wdata_in[2:0];
                caq_pkg::OFS_IVEC: ivec_d = reg_wdata_in[7:0];
                caq_pkg::OFS_BSET2: begin
                    b2_d = b2_q | reg_wdata_in;
                    fif.arm = reg_wdata_in[caq_pkg::B2_TACQ];
                end
                caq_pkg::OFS_BCLR2: begin
                    b2_d = b2_q & ~reg_wdata_in;
                    fif.disarm = reg_wdata_in[caq_pkg::B2_TACQ];
                end
                caq_pkg::OFS_WTADDR: wta_d = reg_wdata_in[BUF_AW-1:0];
                caq_pkg::OFS_RTADDR: rta_d = reg_wdata_in[BUF_AW-1:0];
                caq_pkg::OFS_TWH: twh_d = reg_wdata_in;
                caq_pkg::OFS_TWL: begin
                    // lower half commits; equal locations never store
                    tw_we = b2_q[caq_pkg::B2_RAND] && (wta_q != rta_q) &&
                        (st_q == caq_pkg::SQ_IDLE);
                end
                caq_pkg::OFS_TEVT: fif.push = 1'b1;
                caq_pkg::OFS_EVRST: ev_rst = 1'b1;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            rdata_d = 32'h0000_0000;
            if (thr_hit) begin
                rdata_d = {23'h0, thr_q[thr_idx]};
            end
            case (reg_addr_in)
                caq_pkg::OFS_BUF: begin
                    if (b2_q[caq_pkg::B2_RAND]) begin
                        rdata_d = buf_q[rta_q];
                    end else if (evs_q == 6'h00) begin
                        rdata_d = {5'h0, caq_pkg::TYP_INV, 24'h0};
                    end else begin
                        rdata_d = rd_word;
                        rptr_d = rptr_q + 1'b1;
                        rd_eoe = rd_word[26:24] == caq_pkg::TYP_EOE;
                    end
                end
                caq_pkg::OFS_MCST: rdata_d = {24'h0, mcst_q};
                caq_pkg::OFS_ILVL: rdata_d = {29'h0, ilvl_q};
                caq_pkg::OFS_IVEC: rdata_d = {24'h0, ivec_q};
                caq_pkg::OFS_STAT: rdata_d = {29'h0, full_q, busy_q, dr_q};
                caq_pkg::OFS_EVL: rdata_d = {16'h0, evc_q[15:0]};
                caq_pkg::OFS_EVH: rdata_d = {24'h0, evc_q[23:16]};
                caq_pkg::OFS_BSET2: rdata_d = {16'h0, b2_q};
                caq_pkg::OFS_BCLR2: rdata_d = {16'h0, b2_q};
                default: ;
            endcase
        end
    end

    // register group flops
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            b2_q <= caq_pkg::B2_RST;
            twh_q <= 16'h0000;
            mcst_q <= caq_pkg::MCST_RST;
            ivec_q <= caq_pkg::IVEC_RST;
            ilvl_q <= caq_pkg::ILVL_RST;
            wta_q <= '0;
            rta_q <= '0;
            rptr_q <= '0;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            b2_q <= b2_d;
            twh_q <= twh_d;
            mcst_q <= mcst_d;
            ivec_q <= ivec_d;
            ilvl_q <= ilvl_d;
            wta_q <= wta_d;
            rta_q <= rta_d;
            rptr_q <= rptr_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    // thresholds are left unreset so a soft restart keeps them
    always_ff @(posedge sys_clk_in) begin
        if (thr_we) begin
            thr_q[thr_idx] <= reg_wdata_in[8:0];
        end
    end

    // channel picked at each scan step, and its acceptance
    always_comb begin
        ch = {idx_q[0], idx_q[4:1]};
        thr = thr_q[ch];
        if (b2_q[caq_pkg::B2_TACQ]) begin
            val = fif.pop_data[12:0];
            ovf = fif.pop_data[caq_pkg::TW_OVF_BIT];
            acc = 1'b1;
        end else begin
            val = sv_q[ch*13 +: 13];
            ovf = so_q[ch];
            acc = !thr[caq_pkg::THR_KILL_BIT] &&
                (!b2_q[caq_pkg::B2_ZSUP] || val[12:5] >= thr[7:0]) &&
                (!b2_q[caq_pkg::B2_OVSUP] || !ovf);
        end
    end

    // sequence from gate to stored event
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        evs_d = evs_q;
        evc_d = evc_q;
        wptr_d = wptr_q;
        sv_d = sv_q;
        so_d = so_q;
        sq_we = 1'b0;
        sq_wa = wptr_q;
        sq_wd = 32'h0000_0000;
        fif.pop = 1'b0;
        cnt_ext = BUF_AW'(cnt_q);
        case (st_q)
            caq_pkg::SQ_IDLE: begin
                if (gate_in && !gate_q) begin
                    st_d = caq_pkg::SQ_CONV;
                    evc_d = evc_q + 24'h000001;
                    tmr_d = caq_pkg::CONV_CYC - 16'h0001;
                end
            end
            caq_pkg::SQ_CONV: begin
                if (fast_clear_in) begin
                    st_d = caq_pkg::SQ_IDLE;
                end else if (tmr_q == 16'h0000) begin
                    st_d = caq_pkg::SQ_SAMPLE;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            caq_pkg::SQ_SAMPLE: begin
                sv_d = chan_value_in;
                so_d = chan_ovf_in;
                idx_d = 5'h00;
                cnt_d = 6'h00;
                st_d = caq_pkg::SQ_SCAN;
            end
            caq_pkg::SQ_SCAN: begin
                // data go after the header slot, header is written last
                fif.pop = b2_q[caq_pkg::B2_TACQ];
                if (acc) begin
                    sq_we = 1'b1;
                    sq_wa = wptr_q + cnt_ext + 1'b1;
                    sq_wd = {5'h0, caq_pkg::TYP_DAT, 3'h0, ch, 2'h0, ovf, val};
                    cnt_d = cnt_q + 6'h01;
                end
                idx_d = idx_q + 5'h01;
                if (idx_q == 5'(NCH - 1)) begin
                    if (cnt_d == 6'h00 && !b2_q[caq_pkg::B2_EMPTY]) begin
                        st_d = caq_pkg::SQ_IDLE;
                    end else begin
                        st_d = caq_pkg::SQ_TRAIL;
                    end
                end
            end
            caq_pkg::SQ_TRAIL: begin
                sq_we = 1'b1;
                sq_wa = wptr_q + cnt_ext + 1'b1;
                sq_wd = {5'h0, caq_pkg::TYP_EOE, evc_q};
                st_d = caq_pkg::SQ_HEAD;
            end
            caq_pkg::SQ_HEAD: begin
                sq_we = 1'b1;
                sq_wd = {5'h0, caq_pkg::TYP_HDR, 10'h0, cnt_q, 8'h0};
                wptr_d = wptr_q + cnt_ext + 2'd2;
                evs_d = evs_q + 6'h01;
                st_d = (evs_d == EVMAX) ? caq_pkg::SQ_FULL :
                    caq_pkg::SQ_IDLE;
            end
            caq_pkg::SQ_FULL: begin
                // gates are ignored here; busy stays up until a read frees
                if (evs_q != EVMAX) begin
                    st_d = caq_pkg::SQ_IDLE;
                end
            end
            default: st_d = caq_pkg::SQ_IDLE;
        endcase
        // trailer read frees an event; may coincide with a store
        if (rd_eoe) begin
            evs_d = evs_d - 6'h01;
        end
        if (ev_rst) begin
            evc_d = 24'h000000;
        end
        busy_d = st_d != caq_pkg::SQ_IDLE;
        full_d = evs_d == EVMAX;
        dr_d = evs_d != 6'h00;
    end

    // sequencer group flops
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= caq_pkg::SQ_IDLE;
            tmr_q <= 16'h0000;
            idx_q <= 5'h00;
            cnt_q <= 6'h00;
            evs_q <= 6'h00;
            evc_q <= 24'h000000;
            wptr_q <= '0;
            sv_q <= '0;
            so_q <= '0;
            gate_q <= 1'b0;
            busy_q <= 1'b0;
            full_q <= 1'b0;
            dr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            evs_q <= evs_d;
            evc_q <= evc_d;
            wptr_q <= wptr_d;
            sv_q <= sv_d;
            so_q <= so_d;
            gate_q <= gate_in;
            busy_q <= busy_d;
            full_q <= full_d;
            dr_q <= dr_d;
        end
    end

    // buffer port: the sequencer owns it, test writes only while idle
    always_comb begin
        buf_we = sq_we | tw_we;
        buf_wa = sq_we ? sq_wa : wta_q;
        buf_wd = sq_we ? sq_wd : {twh_q, reg_wdata_in};
    end

    // buffer storage is not cleared; empty is kept by pointers and count
    always_ff @(posedge sys_clk_in) begin
        if (buf_we) begin
            buf_q[buf_wa] <= buf_wd;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_ack_out = ack_q;
    assign busy_out = busy_q;
    assign data_ready_out = dr_q;
    assign buf_full_out = full_q;
    assign irq_level_out = ilvl_q;
    assign irq_vector_out = ivec_q;
    assign irq_enable_out = ilvl_q != 3'h0;
endmodule

// *** caq_pkg.sv ***
// constants, offsets and types shared by the acquisition sequencer files
package caq_pkg;
    // channel and buffer geometry
    localparam int NCH = 32;
    localparam int BUF_AW = 11;
    localparam int MAX_EVT = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;

    // register offsets (16-bit byte offsets)
    localparam logic [15:0] OFS_BUF = 16'h0000;
    localparam logic [15:0] OFS_MCST = 16'h1004;
    localparam logic [15:0] OFS_ILVL = 16'h100a;
    localparam logic [15:0] OFS_IVEC = 16'h100c;
    localparam logic [15:0] OFS_STAT = 16'h100e;
    localparam logic [15:0] OFS_EVL = 16'h1024;
    localparam logic [15:0] OFS_EVH = 16'h1026;
    localparam logic [15:0] OFS_BSET2 = 16'h1032;
    localparam logic [15:0] OFS_BCLR2 = 16'h1034;
    localparam logic [15:0] OFS_WTADDR = 16'h1036;
    localparam logic [15:0] OFS_TWH = 16'h1038;
    localparam logic [15:0] OFS_TWL = 16'h103a;
    localparam logic [15:0] OFS_TEVT = 16'h103e;
    localparam logic [15:0] OFS_EVRST = 16'h1040;
    localparam logic [15:0] OFS_RTADDR = 16'h1064;
    localparam logic [15:0] OFS_THR_LO = 16'h1080;
    localparam logic [15:0] OFS_THR_HI = 16'h10be;

    // second flag register bit positions
    localparam int B2_RAND = 0;
    localparam int B2_OVSUP = 3;
    localparam int B2_ZSUP = 4;
    localparam int B2_TACQ = 6;
    localparam int B2_EMPTY = 12;

    // values after reset
    localparam logic [7:0] MCST_RST = 8'haa;
    localparam logic [2:0] ILVL_RST = 3'h0;
    localparam logic [7:0] IVEC_RST = 8'h00;
    localparam logic [15:0] B2_RST = 16'h0000;

    // output word type codes, in bits 26..24
    localparam logic [2:0] TYP_DAT = 3'h0;
    localparam logic [2:0] TYP_HDR = 3'h2;
    localparam logic [2:0] TYP_EOE = 3'h4;
    localparam logic [2:0] TYP_INV = 3'h6;
    localparam int TYP_LSB = 24;
    localparam int TW_OVF_BIT = 13;
    localparam int THR_KILL_BIT = 8;

    // conversion time
    localparam int CLK_NS = 5;
    localparam int CONV_NS = 600;
    localparam logic [15:0] CONV_CYC = 16'((CONV_NS + CLK_NS - 1) / CLK_NS);

    typedef enum {
        SQ_IDLE, SQ_CONV, SQ_SAMPLE, SQ_SCAN, SQ_TRAIL, SQ_HEAD, SQ_FULL
    } caq_state_type;
endpackage

// *** caq_fifo_if.sv ***
// interface between the sequencer and its test event fifo
`timescale 1ns/1ps
interface caq_fifo_if;
    logic push;
    logic [15:0] push_data;
    logic pop;
    logic [15:0] pop_data;
    logic arm;
    logic disarm;
    modport fifo (input push, push_data, pop, arm, disarm, output pop_data);
    modport ctrl (output push, push_data, pop, arm, disarm, input pop_data);
endinterface

// *** caq_test_fifo.sv ***
// circular test event fifo with held write and read pointers
`timescale 1ns/1ps
module caq_test_fifo #(
    parameter int DEPTH = caq_pkg::FIFO_DEPTH,
    parameter int AW = caq_pkg::FIFO_AW
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // sequencer side
    caq_fifo_if.fifo f
);
    logic [15:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic wh_q, wh_d, rh_q, rh_d;
    logic wr_ok;

    // arm resets the write side, disarm the read side; each holds its own side and frees the other
    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        wh_d = wh_q;
        rh_d = rh_q;
        wr_ok = 1'b0;
        if (f.arm) begin
            wp_d = '0;
            wh_d = 1'b1;
            rh_d = 1'b0;
        end else if (f.disarm) begin
            rp_d = '0;
            wh_d = 1'b0;
            rh_d = 1'b1;
        end else begin
            if (f.push && !wh_q) begin
                wr_ok = 1'b1;
                wp_d = wp_q + 1'b1; // wraps: extra words overwrite
            end
            if (f.pop && !rh_q) begin
                rp_d = rp_q + 1'b1; // full lap per event
            end
        end
    end

    // pointer registers; both held until software walks the sequence
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_q <= '0;
            rp_q <= '0;
            wh_q <= 1'b1;
            rh_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            wh_q <= wh_d;
            rh_q <= rh_d;
        end
    end

    // storage has no reset: unwritten words are undefined by design
    always_ff @(posedge sys_clk_in) begin
        if (wr_ok) begin
            mem_q[wp_q] <= f.push_data;
        end
    end

    assign f.pop_data = mem_q[rp_q];
endmodule

// *** caq_seq_properties.sv ***
// concurrent checks on the acquisition sequencer ports
`timescale 1ns/1ps
module caq_seq_properties (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // watched inputs
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic gate_in,
    input wire logic fast_clear_in,
    // watched outputs
    input wire logic reg_ack_out,
    input wire logic busy_out,
    input wire logic data_ready_out,
    input wire logic buf_full_out,
    input wire logic [2:0] irq_level_out,
    input wire logic [7:0] irq_vector_out,
    input wire logic irq_enable_out
);
    logic [15:0] run_q;
    logic [15:0] run_d;
    logic fc_q;
    logic fc_d;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // busy run length; abort noted only inside the conversion window
    always_comb begin
        run_d = busy_out ? run_q + 16'h0001 : 16'h0000;
        fc_d = busy_out && (fc_q || (fast_clear_in && run_q < 16'h0070));
    end
    // counters are helpers only, so reset them with the design
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_q <= 16'h0000;
            fc_q <= 1'b0;
        end else begin
            run_q <= run_d;
            fc_q <= fc_d;
        end
    end
    sequence gate_rise;
        !busy_out && gate_in && !$past(gate_in);
    endsequence
    sequence strobe;
        reg_wr_in || reg_rd_in;
    endsequence
    chk_ack_follows: assert property (strobe |=> reg_ack_out)
        else $error("no ack after a strobe");
    chk_ack_cause: assert property (
        reg_ack_out |-> $past(reg_wr_in || reg_rd_in))
        else $error("ack without a strobe");
    chk_busy_start: assert property (gate_rise |=> busy_out)
        else $error("busy not raised by gate");
    chk_reset_state: assert property ($rose(rst_b_in) |->
        !busy_out && !data_ready_out && !buf_full_out &&
        irq_level_out == 3'h0 && irq_vector_out == 8'h00)
        else $error("state after reset wrong");
    chk_irq_enable: assert property (
        irq_enable_out == (irq_level_out != 3'h0))
        else $error("interrupt enable wrong");
    chk_full_busy: assert property (
        buf_full_out |-> busy_out && data_ready_out)
        else $error("full without busy");
    chk_busy_span: assert property ($fell(busy_out) |->
        (fc_q ? run_q <= 16'h007d : run_q >= 16'h0078))
        else $error("busy length wrong");
    chk_abort_quick: assert property (fast_clear_in && busy_out &&
        run_q > 16'h0002 && run_q < 16'h0070 |-> ##[1:3] !busy_out)
        else $error("fast clear did not abort");
endmodule

bind caq_sequencer caq_seq_properties u_props (.sys_clk_in, .rst_b_in,
    .reg_wr_in, .reg_rd_in, .gate_in, .fast_clear_in, .reg_ack_out,
    .busy_out, .data_ready_out, .buf_full_out, .irq_level_out,
    .irq_vector_out, .irq_enable_out);

// *** caq_host_model.sv ***
// host cpu model: one-cycle strobes on falling edges, bounded ack wait
`timescale 1ns/1ps
module caq_host_model (
    // clock
    input wire logic sys_clk_in,
    // answer from the device
    input wire logic [31:0] rdata_in,
    input wire logic ack_in,
    // request to the device, and the hang flag
    output logic [15:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic hung_out
);
    initial begin
        addr_out = 16'h0000;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        hung_out = 1'b0;
    end
    // address stays put after the strobe until the next access
    task automatic acc(input logic wr, input logic [15:0] a,
        input logic [15:0] d, output logic [31:0] q);
        int n;
        @(negedge sys_clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = wr;
        rd_out = !wr;
        @(negedge sys_clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        q = 32'h0;
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk_in);
            if (ack_in === 1'b1) break;
        end
        q = rdata_in;
        if (n == 8) hung_out = 1'b1;
    endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic gate_in = 1'b0;
    logic fast_clear_in = 1'b0;
    logic [caq_pkg::NCH*13-1:0] cval = '0;
    logic [caq_pkg::NCH-1:0] covf = '0;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic ack;
    logic hung;
    logic busy;
    logic dready;
    logic full;
    logic irq_en;
    logic [31:0] q;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [8:0] thr [32];
    logic [13:0] tw [32];
    logic [18:0] eq [$];
    int fails = 0;
    int tests_run = 0;
    int evn = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    caq_host_model host (.sys_clk_in(sys_clk_in), .rdata_in(rdata),
        .ack_in(ack), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .hung_out(hung));
    caq_sequencer dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_ack_out(ack),
        .gate_in(gate_in), .fast_clear_in(fast_clear_in),
        .chan_value_in(cval), .chan_ovf_in(covf), .busy_out(busy),
        .data_ready_out(dready), .buf_full_out(full),
        .irq_level_out(), .irq_vector_out(), .irq_enable_out(irq_en));
    task automatic test_done;
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic hang;
        fails++;
        test_done();
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [15:0] d);
        host.acc(w, a, d, q);
        if (hung !== 1'b0) hang();
    endtask
    // readout position i carries channel i/2, plus 16 on odd positions
    function automatic logic [4:0] och(int i);
        return 5'((i % 2) * 16 + i / 2);
    endfunction
    function automatic logic ok(int c);
        logic [12:0] v;
        v = cval[c*13 +: 13];
        return !thr[c][8] && v[12:5] >= thr[c][7:0] && !covf[c];
    endfunction
    // gate pulse, optional fast clear in mid conversion, bounded wait
    task automatic gate(input logic fc);
        int n;
        @(negedge sys_clk_in);
        gate_in = 1'b1;
        @(negedge sys_clk_in);
        gate_in = 1'b0;
        chk(busy, 1'b1);
        repeat (10) @(negedge sys_clk_in);
        fast_clear_in = fc;
        @(negedge sys_clk_in);
        fast_clear_in = 1'b0;
        for (n = 0; n < 400; n++) begin
            if (busy === 1'b0 || full === 1'b1) break;
            @(negedge sys_clk_in);
        end
        if (n == 400) hang();
    endtask
    // read header, the expected data words and the trailer
    task automatic evt(input int cnt);
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk({q[26:24], q[13:8]}, {caq_pkg::TYP_HDR, 6'(eq.size())});
        foreach (eq[i]) begin
            acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
            chk({q[26:24], q[20:16], q[13:0]}, {3'h0, eq[i]});
        end
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk(q[26:0], {caq_pkg::TYP_EOE, 24'(cnt)});
        eq = {};
    endtask
    task automatic rst_chk;
        rst_b_in = 1'b0;
        repeat (5) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        evn = 0;
        acc(1'b0, caq_pkg::OFS_MCST, 16'h0000);
        chk(q, 32'h000000aa);
        acc(1'b0, caq_pkg::OFS_EVL, 16'h0000);
        chk(q, 32'h00000000);
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk(q[26:24], caq_pkg::TYP_INV);
        acc(1'b0, caq_pkg::OFS_ILVL, 16'h0000);
        chk(q | irq_en, 32'h00000000);
        acc(1'b0, caq_pkg::OFS_IVEC, 16'h0000);
        chk(q, 32'h00000000);
        acc(1'b0, 16'h2000, 16'h0000);
        chk(q, 32'h00000000);
    endtask
    initial begin
        void'($urandom(32'h989f));
        rst_chk();
        acc(1'b1, caq_pkg::OFS_ILVL, 16'h0003);
        chk(irq_en, 1'b1);
        // random charges against random thresholds, channel 5 killed
        for (int c = 0; c < 32; c++) begin
            thr[c] = {c == 5, 8'($urandom_range(255, 1))};
            acc(1'b1, 16'(caq_pkg::OFS_THR_LO + 2 * c), 16'(thr[c]));
        end
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h0018);
        @(negedge sys_clk_in);
        cval = {13{$urandom}};
        covf = $urandom;
        for (int i = 0; i < 32; i++) begin
            if (ok(och(i))) eq.push_back({och(i), covf[och(i)],
                cval[och(i)*13 +: 13]});
        end
        gate(1'b0);
        evn++;
        evt(evn);
        // all rejected: nothing kept, then header and trailer only
        cval = '0;
        gate(1'b0);
        evn++;
        chk(dready, 1'b0);
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h1000);
        gate(1'b0);
        evn++;
        evt(evn);
        gate(1'b1);
        evn++;
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk(q[26:24], caq_pkg::TYP_INV);
        // fifo test event, delivered twice
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h0040);
        acc(1'b1, caq_pkg::OFS_BCLR2, 16'h0040);
        for (int i = 0; i < 32; i++) begin
            tw[i] = 14'($urandom);
            acc(1'b1, caq_pkg::OFS_TEVT, {2'h0, tw[i]});
        end
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h0040);
        repeat (2) begin
            foreach (tw[i]) eq.push_back({och(i), tw[i]});
            gate(1'b0);
            evn++;
            evt(evn);
        end
        acc(1'b1, caq_pkg::OFS_BCLR2, 16'h0040);
        // direct buffer access; a write while locations match is lost
        w1 = $urandom;
        w2 = $urandom;
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h0001);
        acc(1'b1, caq_pkg::OFS_RTADDR, 16'h0007);
        acc(1'b1, caq_pkg::OFS_WTADDR, 16'h0005);
        acc(1'b1, caq_pkg::OFS_TWH, w1[31:16]);
        acc(1'b1, caq_pkg::OFS_TWL, w1[15:0]);
        acc(1'b1, caq_pkg::OFS_WTADDR, 16'h0009);
        acc(1'b1, caq_pkg::OFS_RTADDR, 16'h0009);
        acc(1'b1, caq_pkg::OFS_TWH, w2[31:16]);
        acc(1'b1, caq_pkg::OFS_TWL, w2[15:0]);
        acc(1'b1, caq_pkg::OFS_RTADDR, 16'h0005);
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk(q, w1);
        acc(1'b1, caq_pkg::OFS_WTADDR, 16'h0003);
        acc(1'b1, caq_pkg::OFS_RTADDR, 16'h0009);
        acc(1'b0, caq_pkg::OFS_BUF, 16'h0000);
        chk(q == w2, 1'b0);
        // second reset, then fill with empty events until full
        @(negedge sys_clk_in);
        rst_chk();
        acc(1'b1, caq_pkg::OFS_BSET2, 16'h1008);
        @(negedge sys_clk_in);
        covf = '1;
        repeat (33) gate(1'b0);
        chk({full, busy}, 2'h3);
        acc(1'b0, caq_pkg::OFS_STAT, 16'h0000);
        chk(q, 32'h00000007);
        for (int k = 1; k <= 32; k++) evt(k);
        acc(1'b0, caq_pkg::OFS_EVL, 16'h0000);
        chk(q, 32'h00000020);
        // the counter clear register drops the event count
        acc(1'b1, caq_pkg::OFS_EVRST, 16'h0000);
        acc(1'b0, caq_pkg::OFS_EVL, 16'h0000);
        chk(q, 32'h00000000);
        test_done();
    end
endmodule
